// file: bench/bfc_channel_tb.sv
// Self-checking bench of the bunch feedback channel with short counts.
// Assumes the far-side model in the bench folder and the design sources.
`timescale 1ns/1ps
module bfc_channel_tb;
  import bfc_pkg::*;
  localparam int NB = 8;
  localparam int SATH = 8;
  localparam int MISS = 4;
  localparam int ACQ = 16;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic adc_valid_i = 1'b0;
  logic [7:0] adc_data_i = 8'h00;
  logic [15:0][15:0] coef = '0;
  logic trig_one_i = 1'b0;
  logic trig_two_i = 1'b0;
  logic [3:0] pins = 4'h0;
  logic [15:0] period = 16'h8;
  logic rf_stop = 1'b0;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic stream_on = 1'b0;
  logic adc_ready_o, dac_valid_o, dac_ready, fiducial, rf_mon;
  logic turn_start_o, fid_error_o, acq_start_o, acq_active_o;
  logic [15:0] dac_data_o;
  logic [2:0] bunch_o;
  bfc_led_t led;
  int fails = 0;
  int compares = 0;
  int hist[NB][16];
  logic [15:0] expq[$];
  logic [31:0] seed = 32'd33;
  int age = 100;
  int acq_starts = 0;
  logic fid_prev = 1'b1;
  logic taken = 1'b0;
  always #2 clk_sys_i = !clk_sys_i;
  bfc_channel #(.NB(NB), .SAT_HOLD(SATH), .CLK_MISS(MISS), .ACQ_LEN(ACQ)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .adc_valid_i(adc_valid_i), .adc_data_i(adc_data_i),
    .adc_ready_o(adc_ready_o), .coef_i(coef), .dac_valid_o(dac_valid_o), .dac_data_o(dac_data_o),
    .dac_ready_i(dac_ready), .fiducial_i(fiducial), .rf_clk_mon_i(rf_mon), .trig_one_i(trig_one_i),
    .trig_two_i(trig_two_i), .proc_clock_lock_i(pins[0]), .acq_clock_lock_i(pins[1]),
    .proc_clock_aux_i(pins[2]), .bus_busy_i(pins[3]), .turn_start_o(turn_start_o), .bunch_o(bunch_o),
    .fid_error_o(fid_error_o), .acq_start_o(acq_start_o), .acq_active_o(acq_active_o), .led_o(led));
  bfc_far_model far_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .period_i(period), .rf_stop_i(rf_stop),
    .stall_i(stall), .slow_i(slow), .fiducial_o(fiducial), .rf_clk_mon_o(rf_mon), .dac_ready_o(dac_ready));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] fir_expect(int b);
    longint s;
    s = 0;
    for (int k = 0; k < 16; k++) s += longint'($signed(coef[k])) * hist[b][k];
    if (s > 32767) s = 32767;
    if (s < -32768) s = -32768;
    return s[15:0];
  endfunction
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Sample source and output stalls; an offered sample stands until it is taken.
  always @(negedge clk_sys_i) begin
    if (!adc_valid_i || taken) begin
      if (stream_on) begin
        adc_valid_i <= (rnd() % 8) != 0;
        adc_data_i <= 8'(rnd());
        slow <= 1'(rnd());
      end else begin
        adc_valid_i <= 1'b0;
      end
    end
  end
  // Reference model: per-bunch history, turn delay order and fiducial latency.
  always @(posedge clk_sys_i) begin
    if (!rst_i) begin
      age = (fid_prev && !fiducial) ? 0 : age + 1;
      fid_prev = fiducial;
      if (turn_start_o === 1'b1) check("turn_latency", 16'h1, {15'h0, age >= 1 && age <= 6});
      if (acq_start_o === 1'b1) acq_starts++;
      taken = adc_valid_i && adc_ready_o === 1'b1;
      if (taken) begin
        for (int k = 15; k > 0; k--) hist[bunch_o][k] = hist[bunch_o][k - 1];
        hist[bunch_o][0] = $signed(adc_data_i);
        expq.push_back(fir_expect(bunch_o));
      end
      if (dac_valid_o === 1'b1 && dac_ready) begin
        check("turn_delay", 16'h1, {15'h0, expq.size() >= NB + 1});
        if (expq.size() > 0) check("dac_data", expq.pop_front(), dac_data_o);
      end
    end
  end
  initial begin
    #80000;
    fails++;
    summarize();
  end
  initial begin
    for (int b = 0; b < NB; b++) for (int k = 0; k < 16; k++) hist[b][k] = 0;
    tick(10);
    rst_i = 1'b0;
    check("ready_at_reset", 16'h0, adc_ready_o);
    check("dac_valid_at_reset", 16'h0, dac_valid_o);
    check("leds_at_reset", 16'h0, led);
    $display("test reset done");
    for (int k = 0; k < 16; k++) coef[k] = 16'((rnd() % 64) - 32);
    tick(NB + 1);
    check("ready_after_clear", 16'h1, adc_ready_o);
    stream_on = 1'b1;
    tick(300);
    stall = 1'b1;
    tick(30);
    check("fifo_full_refuses", 16'h0, adc_ready_o);
    stall = 1'b0;
    tick(100);
    stream_on = 1'b0;
    tick(20);
    $display("test stream done");
    for (int k = 0; k < 16; k++) coef[k] = 16'h7fff;
    stream_on = 1'b1;
    tick(40);
    check("sat_red", 16'h1, led.saturation_red);
    stream_on = 1'b0;
    tick(10);
    coef = '0;
    stream_on = 1'b1;
    tick(60);
    stream_on = 1'b0;
    tick(SATH + 10);
    check("sat_green", 16'h0, led.saturation_red);
    $display("test saturation done");
    check("fid_ok", 16'h0, fid_error_o);
    period = 16'(NB + 1);
    tick(5 * NB);
    check("fid_wrong_freq", 16'h1, fid_error_o);
    check("fid_led_on", 16'h1, led.fiducial_error_red);
    period = 16'(NB);
    tick(5 * NB);
    check("fid_recovered", 16'h0, fid_error_o);
    period = 16'h0;
    tick(2 * NB + 10);
    check("fid_absent", 16'h1, led.fiducial_error_red);
    period = 16'(NB);
    tick(6 * NB);
    check("fid_led_off", 16'h0, led.fiducial_error_red);
    $display("test fiducial done");
    rf_stop = 1'b1;
    tick(MISS + 8);
    check("clock_missing", 16'h1, led.clock_missing_red);
    rf_stop = 1'b0;
    tick(5);
    check("clock_present", 16'h0, led.clock_missing_red);
    $display("test rf clock done");
    repeat (40) begin
      trig_one_i = 1'(rnd());
      tick(1);
    end
    tick(6);
    check("trig_one_ignored", 16'h0, 16'(acq_starts));
    trig_two_i = 1'b1;
    tick(8);
    check("acq_started", 16'h1, 16'(acq_starts));
    check("acq_active_led", 16'h1, led.aux_indicator_two);
    trig_two_i = 1'b0;
    tick(2);
    trig_two_i = 1'b1;
    tick(4);
    check("acq_retrigger", 16'h1, 16'(acq_starts));
    tick(ACQ + 4);
    check("acq_ended", 16'h0, acq_active_o);
    trig_two_i = 1'b0;
    $display("test acquisition done");
    for (int i = 0; i < 10; i++) begin
      pins = (i < 2) ? {4{i[0]}} : 4'(rnd());
      tick(5);
      check("proc_lock_led", pins[0], led.processing_clock_lock_indicator);
      check("acq_lock_led", pins[1], led.aux_indicator_one);
      check("proc_aux_led", pins[2], led.aux_indicator_three);
      check("bus_led", pins[3], led.bus_activity);
    end
    $display("test indicators done");
    summarize();
  end
endmodule

// file: bench/bfc_far_model.sv
// Far side of the channel: revolution timing source, RF clock monitor and output converter.
// Assumes the bench steers period, clock stop and stalls on the same system clock.
`timescale 1ns/1ps
module bfc_far_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [15:0] period_i,
  input wire logic rf_stop_i,
  input wire logic stall_i,
  input wire logic slow_i,
  output logic fiducial_o,
  output logic rf_clk_mon_o,
  output logic dac_ready_o
);
  logic [15:0] cnt_q;
  logic slow_q;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 16'h0;
      slow_q <= 1'b0;
      fiducial_o <= 1'b1;
      rf_clk_mon_o <= 1'b0;
      dac_ready_o <= 1'b0;
    end else begin
      // Edges sit on clock edges, so the turn never jitters; a zero period means an absent fiducial.
      if (period_i == 16'h0) begin
        cnt_q <= 16'h0;
        fiducial_o <= 1'b1;
      end else begin
        cnt_q <= (cnt_q >= period_i - 16'h1) ? 16'h0 : cnt_q + 16'h1;
        fiducial_o <= (cnt_q >= (period_i >> 1));
      end
      // A stopped RF clock stands still rather than toggling.
      if (!rf_stop_i) begin
        rf_clk_mon_o <= !rf_clk_mon_o;
      end
      slow_q <= !slow_q;
      dac_ready_o <= !stall_i && (!slow_i || slow_q);
    end
  end
endmodule

// file: src/bfc_channel.sv
// Bunch feedback channel: per-bunch filter, buffer, one-turn delay and status indicators.
// Assumes samples arrive on clk_sys_i at one per bunch slot; pins are asynchronous.
// Overview of operation
// - Every bunch of the turn has its own sixteen-tap filter that never mixes bunches.
// - Every filtered result waits one full turn before it goes to the output converter.
// - The falling edge of the revolution fiducial starts a turn.
// - A rising edge on the second trigger starts data acquisition.
// - The first trigger input is ignored.
// - The saturation indicator is green normally and red when the filter saturates.
// - The clock-missing indicator is red while no RF clock activity is seen.
// - The processing clock manager lock shows green when locked and red when not.
// - The fiducial error indicator is red when the fiducial is absent, off frequency or jittery.
// - The first user indicator shows the acquisition clock manager lock.
// - The second user indicator is green while acquisition runs.
// - The bus activity indicator is green while a local bus transaction runs.
// - The third user indicator shows the extra status of the processing clock manager.
`timescale 1ns/1ps
`include "bfc_regs.svh"
module bfc_channel
  import bfc_pkg::*;
#(
  parameter int NB = `BFC_NUM_BUNCH,
  parameter int TAPS = `BFC_NUM_TAPS,
  parameter int SW = `BFC_SAMPLE_W,
  parameter int CW = `BFC_COEF_W,
  parameter int OW = `BFC_DAC_W,
  parameter int DEPTH = `BFC_FIFO_DEPTH,
  parameter int SAT_HOLD = `BFC_SAT_HOLD,
  parameter int CLK_MISS = `BFC_CLK_MISS_CYC,
  parameter int ACQ_LEN = `BFC_ACQ_LEN
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic adc_valid_i,
  input wire logic [SW-1:0] adc_data_i,
  output logic adc_ready_o,
  input wire logic [TAPS-1:0][CW-1:0] coef_i,
  output logic dac_valid_o,
  output logic [OW-1:0] dac_data_o,
  input wire logic dac_ready_i,
  input wire logic fiducial_i,
  input wire logic rf_clk_mon_i,
  input wire logic trig_one_i,
  input wire logic trig_two_i,
  input wire logic proc_clock_lock_i,
  input wire logic acq_clock_lock_i,
  input wire logic proc_clock_aux_i,
  input wire logic bus_busy_i,
  output logic turn_start_o,
  output logic [$clog2(NB)-1:0] bunch_o,
  output logic fid_error_o,
  output logic acq_start_o,
  output logic acq_active_o,
  output bfc_led_t led_o
);
  localparam int BW = $clog2(NB);
  localparam int FID_MISS = 2 * NB;
  localparam int PW = $clog2(FID_MISS + 1);
  localparam int HW = $clog2(SAT_HOLD + 1);
  localparam int MW = $clog2(CLK_MISS + 1);
  localparam int QW = $clog2(ACQ_LEN + 1);

  typedef struct packed {
    logic [`BFC_PIN_W-1:0] s1;
    logic [`BFC_PIN_W-1:0] s2;
    logic [`BFC_PIN_W-1:0] s3;
    bfc_fid_st_t fst;
    logic [BW-1:0] slot;
    logic [PW-1:0] per;
    logic fid_err;
    logic turn;
    logic [MW-1:0] miss;
    logic clk_miss;
    logic [HW-1:0] sat_cnt;
    logic [QW-1:0] acq_cnt;
    logic acq_act;
    logic acq_start;
    logic [BW-1:0] dly_ptr;
    logic primed;
    logic dvld;
    logic [OW-1:0] ddat;
    bfc_led_t led;
  } bfc_chan_st_t;

  bfc_chan_st_t q, d;
  logic [OW-1:0] dly_mem_q [NB];
  logic [`BFC_PIN_W-1:0] pins;
  logic take, fir_in_ready;
  logic fir_vld, fir_rdy, fir_sat;
  logic [OW-1:0] fir_dat;
  logic fifo_vld, pop;
  logic [OW-1:0] fifo_dat, dly_rd;
  logic fid_fall, trig_rise, rf_toggle;

  function automatic logic [BW-1:0] bfc_wrap(input logic [BW-1:0] v);
    return (v == BW'(NB - 1)) ? '0 : v + 1'b1;
  endfunction

  // The first trigger is deliberately not collected here.
  assign pins[`BFC_PIN_FID] = fiducial_i;
  assign pins[`BFC_PIN_RFMON] = rf_clk_mon_i;
  assign pins[`BFC_PIN_TRIG] = trig_two_i;
  assign pins[`BFC_PIN_PLOCK] = proc_clock_lock_i;
  assign pins[`BFC_PIN_ALOCK] = acq_clock_lock_i;
  assign pins[`BFC_PIN_PAUX] = proc_clock_aux_i;

  assign fid_fall = q.s3[`BFC_PIN_FID] & ~q.s2[`BFC_PIN_FID];
  assign trig_rise = q.s2[`BFC_PIN_TRIG] & ~q.s3[`BFC_PIN_TRIG];
  assign rf_toggle = q.s2[`BFC_PIN_RFMON] ^ q.s3[`BFC_PIN_RFMON];

  assign adc_ready_o = fir_in_ready;
  assign take = adc_valid_i & fir_in_ready;
  assign pop = fifo_vld & (~q.dvld | dac_ready_i);
  assign dly_rd = dly_mem_q[q.dly_ptr];

  bfc_fir #(
    .NB(NB),
    .TAPS(TAPS),
    .SW(SW),
    .CW(CW),
    .OW(OW)
  ) u_fir (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(adc_valid_i),
    .in_ready_o(fir_in_ready),
    .in_sample_i(adc_data_i),
    .in_bunch_i(q.slot),
    .coef_i(coef_i),
    .out_valid_o(fir_vld),
    .out_ready_i(fir_rdy),
    .out_data_o(fir_dat),
    .out_sat_o(fir_sat)
  );

  bfc_fifo #(
    .W(OW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(fir_vld),
    .in_data_i(fir_dat),
    .in_ready_o(fir_rdy),
    .out_valid_o(fifo_vld),
    .out_data_o(fifo_dat),
    .out_ready_i(pop)
  );

  always_comb begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.turn = 1'b0;
    d.acq_start = 1'b0;
    // A new turn restarts the bunch numbering at slot zero.
    if (fid_fall) begin
      d.slot = '0;
    end else if (take) begin
      d.slot = bfc_wrap(q.slot);
    end
    // Exact period match relies on the fiducial edge being steady to one clock cycle.
    if (fid_fall) begin
      d.per = '0;
      d.turn = 1'b1;
      d.fst = FID_TRACK;
      if (q.fst == FID_TRACK) begin
        d.fid_err = (q.per != PW'(NB - 1));
      end
    end else if (q.per != PW'(FID_MISS)) begin
      d.per = q.per + 1'b1;
    end else begin
      d.fid_err = 1'b1;
      d.fst = FID_IDLE;
    end
    if (rf_toggle) begin
      d.miss = '0;
      d.clk_miss = 1'b0;
    end else if (q.miss != MW'(CLK_MISS)) begin
      d.miss = q.miss + 1'b1;
    end else begin
      d.clk_miss = 1'b1;
    end
    // Saturation is stretched so a single clipped bunch stays visible.
    if (fir_vld & fir_rdy & fir_sat) begin
      d.sat_cnt = HW'(SAT_HOLD);
    end else if (q.sat_cnt != '0) begin
      d.sat_cnt = q.sat_cnt - 1'b1;
    end
    if (trig_rise & ~q.acq_act) begin
      d.acq_act = 1'b1;
      d.acq_start = 1'b1;
      d.acq_cnt = QW'(ACQ_LEN - 1);
    end else if (q.acq_act) begin
      if (q.acq_cnt == '0) begin
        d.acq_act = 1'b0;
      end else begin
        d.acq_cnt = q.acq_cnt - 1'b1;
      end
    end
    // During the first turn the delay line only fills; the unwritten words it reads out then are not presented.
    if (pop) begin
      d.dly_ptr = bfc_wrap(q.dly_ptr);
      d.ddat = dly_rd;
      d.dvld = q.primed;
      if (q.dly_ptr == BW'(NB - 1)) begin
        d.primed = 1'b1;
      end
    end else if (dac_ready_i) begin
      d.dvld = 1'b0;
    end
    d.led.bus_activity = bus_busy_i;
    d.led.saturation_red = (d.sat_cnt != '0);
    d.led.clock_missing_red = d.clk_miss;
    d.led.processing_clock_lock_indicator = q.s2[`BFC_PIN_PLOCK];
    d.led.fiducial_error_red = d.fid_err;
    d.led.aux_indicator_one = q.s2[`BFC_PIN_ALOCK];
    d.led.aux_indicator_two = d.acq_act;
    d.led.aux_indicator_three = q.s2[`BFC_PIN_PAUX];
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (pop) begin
      dly_mem_q[q.dly_ptr] <= fifo_dat;
    end
  end

  assign dac_valid_o = q.dvld;
  assign dac_data_o = q.ddat;
  assign turn_start_o = q.turn;
  assign bunch_o = q.slot;
  assign fid_error_o = q.fid_err;
  assign acq_start_o = q.acq_start;
  assign acq_active_o = q.acq_act;
  assign led_o = q.led;

  default clocking chan_cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_fid_fall;
    q.s3[`BFC_PIN_FID] && !q.s2[`BFC_PIN_FID];
  endsequence

  sequence s_turn_begins;
    turn_start_o && bunch_o == '0;
  endsequence

  a_turn_on_fall: assert property (s_fid_fall |=> s_turn_begins)
    else $error("falling fiducial did not start a turn");
  a_fid_bad_period: assert property (s_fid_fall and (q.fst == FID_TRACK && q.per != PW'(NB - 1))
      |=> fid_error_o && led_o.fiducial_error_red)
    else $error("wrong fiducial period not flagged");
  a_fid_good_period: assert property (s_fid_fall and (q.fst == FID_TRACK && q.per == PW'(NB - 1))
      |=> !fid_error_o)
    else $error("correct fiducial period flagged");
  a_fid_absent: assert property (q.per == PW'(FID_MISS) && !fid_fall
      |=> led_o.fiducial_error_red)
    else $error("absent fiducial not flagged");
  a_trig_start: assert property (trig_rise && !acq_active_o
      |=> acq_start_o && led_o.aux_indicator_two ##1 !acq_start_o)
    else $error("trigger did not start one acquisition");
  a_acq_led: assert property (led_o.aux_indicator_two == acq_active_o)
    else $error("acquisition indicator disagrees");
  a_clk_seen: assert property (rf_toggle |=> !led_o.clock_missing_red)
    else $error("clock activity still shows missing");
  a_clk_lost: assert property (!rf_toggle && q.miss == MW'(CLK_MISS) |=> led_o.clock_missing_red)
    else $error("missing clock not shown");
  a_sat_hold: assert property (fir_vld && fir_rdy && fir_sat |=> led_o.saturation_red [*8])
    else $error("saturation indicator not held");
  a_plock_led: assert property (proc_clock_lock_i [*3] |=> led_o.processing_clock_lock_indicator)
    else $error("processing lock not shown");
  a_alock_led: assert property (!acq_clock_lock_i [*3] |=> !led_o.aux_indicator_one)
    else $error("acquisition unlock not shown");
  a_paux_led: assert property (proc_clock_aux_i [*3] |=> led_o.aux_indicator_three)
    else $error("processing clock status not shown");
  a_bus_led: assert property (bus_busy_i |=> led_o.bus_activity)
    else $error("bus activity not shown");
  a_delay_primed: assert property (dac_valid_o |-> q.primed)
    else $error("output presented before one turn elapsed");
  a_bunch_wrap: assert property (take && !fid_fall && bunch_o == BW'(NB - 1) |=> bunch_o == '0)
    else $error("bunch index did not wrap");
  // Longer-lived behaviour: output holding, acquisition end and re-arming after a lost fiducial.
  a_dac_hold: assert property (dac_valid_o && !dac_ready_i |=> dac_valid_o && $stable(dac_data_o))
    else $error("output word changed before it was taken");
  a_turn_from_fall: assert property (turn_start_o |-> $past(fid_fall))
    else $error("turn started without a falling fiducial");
  a_acq_retrig: assert property (trig_rise && acq_active_o |=> !acq_start_o)
    else $error("trigger restarted a running acquisition");
  a_acq_length: assert property (acq_active_o && q.acq_cnt == '0 |=> !acq_active_o)
    else $error("acquisition did not end after its count");
  a_fid_rearm: assert property (s_fid_fall and (q.fst == FID_IDLE) |=> fid_error_o == $past(fid_error_o))
    else $error("first edge after re-arming was judged");
  a_bus_quiet: assert property (!bus_busy_i |=> !led_o.bus_activity)
    else $error("bus activity shown while idle");
endmodule

// file: src/bfc_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module bfc_fifo
  import bfc_pkg::*;
#(
  parameter int W = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } bfc_fifo_st_t;
  bfc_fifo_st_t q, d;
  logic [W-1:0] mem_q [DEPTH];
  logic push, pop;

  function automatic logic [AW-1:0] bfc_next(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready_o = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o = mem_q[q.rp];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    d = q;
    if (push) begin
      d.wp = bfc_next(q.wp);
    end
    if (pop) begin
      d.rp = bfc_next(q.rp);
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[q.wp] <= in_data_i;
    end
  end
endmodule

// file: src/bfc_fir.sv
// Bunch-multiplexed filter: every bunch slot keeps its own tap history.
// Assumes the bunch index arrives with each sample, on the same clock.
`timescale 1ns/1ps
module bfc_fir
  import bfc_pkg::*;
#(
  parameter int NB = 328,
  parameter int TAPS = 16,
  parameter int SW = 8,
  parameter int CW = 16,
  parameter int OW = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [SW-1:0] in_sample_i,
  input wire logic [$clog2(NB)-1:0] in_bunch_i,
  input wire logic [TAPS-1:0][CW-1:0] coef_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [OW-1:0] out_data_o,
  output logic out_sat_o
);
  localparam int AW = SW + CW + $clog2(TAPS);
  localparam int BI = $clog2(NB);
  localparam logic signed [AW-1:0] MAXV = {{(AW-OW+1){1'b0}}, {(OW-1){1'b1}}};
  localparam logic signed [AW-1:0] MINV = {{(AW-OW+1){1'b1}}, {(OW-1){1'b0}}};
  typedef struct packed {
    logic vld;
    logic [OW-1:0] dat;
    logic sat;
    logic swept;
    logic [BI-1:0] clr;
  } bfc_fir_st_t;
  bfc_fir_st_t q, d;
  logic signed [SW-1:0] hist_q [NB][TAPS-1];
  logic take;
  logic signed [AW-1:0] acc;

  // No sample is taken until every history row has been cleared after reset.
  assign in_ready_o = q.swept & (~q.vld | out_ready_i);
  assign take = in_valid_i & in_ready_o;

  // Each bunch sees only its own history row, so bunches never mix.
  always_comb begin
    logic signed [SW+CW-1:0] prod;
    prod = $signed(coef_i[0]) * $signed(in_sample_i);
    acc = AW'(prod);
    for (int k = 1; k < TAPS; k++) begin
      prod = $signed(coef_i[k]) * hist_q[in_bunch_i][k-1];
      acc = acc + AW'(prod);
    end
  end

  always_comb begin
    d = q;
    if (!q.swept) begin
      d.clr = q.clr + 1'b1;
      d.swept = (q.clr == BI'(NB - 1));
    end
    if (out_ready_i) begin
      d.vld = 1'b0;
    end
    if (take) begin
      d.vld = 1'b1;
      d.sat = 1'b0;
      d.dat = acc[OW-1:0];
      if (acc > MAXV) begin
        d.dat = MAXV[OW-1:0];
        d.sat = 1'b1;
      end else if (acc < MINV) begin
        d.dat = MINV[OW-1:0];
        d.sat = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // After reset one bunch row a clock is zeroed, so no filter starts from unknown history.
  always_ff @(posedge clk_sys_i) begin
    if (!q.swept) begin
      for (int k = 0; k < TAPS - 1; k++) begin
        hist_q[q.clr][k] <= '0;
      end
    end else if (take) begin
      hist_q[in_bunch_i][0] <= $signed(in_sample_i);
      for (int k = 1; k < TAPS - 1; k++) begin
        hist_q[in_bunch_i][k] <= hist_q[in_bunch_i][k-1];
      end
    end
  end

  assign out_valid_o = q.vld;
  assign out_data_o = q.dat;
  assign out_sat_o = q.sat;

  default clocking fir_cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_fir_take_out: assert property (take |=> out_valid_o)
    else $error("filter result missing after an accepted sample");
  a_fir_clamp_value: assert property (out_valid_o && out_sat_o |->
      (out_data_o == MAXV[OW-1:0] || out_data_o == MINV[OW-1:0]))
    else $error("saturated result is not the extreme value");
  a_fir_clamp_flag: assert property (take && (acc > MAXV) |=> out_sat_o)
    else $error("overflow did not raise saturation");
endmodule

// file: src/bfc_pkg.sv
// Types of the bunch feedback channel.
// Assumes nothing of its surroundings.
package bfc_pkg;
  typedef struct packed {
    logic bus_activity;
    logic saturation_red;
    logic clock_missing_red;
    logic processing_clock_lock_indicator;
    logic fiducial_error_red;
    logic aux_indicator_one;
    logic aux_indicator_two;
    logic aux_indicator_three;
  } bfc_led_t;
  typedef enum logic [0:0] {FID_IDLE, FID_TRACK} bfc_fid_st_t;
endpackage

// file: src/bfc_regs.svh
// Constants shared by the bunch feedback channel: sizes, pin positions and timing counts.
// Assumes it is included by bare name from the design files, before the package import.
`ifndef BFC_REGS_SVH
`define BFC_REGS_SVH
`define BFC_NUM_BUNCH 328
`define BFC_NUM_TAPS 16
`define BFC_SAMPLE_W 8
`define BFC_COEF_W 16
`define BFC_DAC_W 16
`define BFC_FIFO_DEPTH 4
`define BFC_SAT_HOLD 1024
`define BFC_CLK_MISS_CYC 64
`define BFC_ACQ_LEN 4096
`define BFC_PIN_W 6
`define BFC_PIN_FID 0
`define BFC_PIN_RFMON 1
`define BFC_PIN_TRIG 2
`define BFC_PIN_PLOCK 3
`define BFC_PIN_ALOCK 4
`define BFC_PIN_PAUX 5
`endif
